// *** include/sps_regs.vh ***
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// fixed upper part of the seven-bit bus address
`define SPS_ADDR_HI      4'hb
// decoded three-level strap codes
`define SPS_LVL_LOW      2'h0
`define SPS_LVL_OPEN     2'h1
`define SPS_LVL_HIGH     2'h2
// register storage
`define SPS_AW           10
`define SPS_DEPTH        1024
`define SPS_PTR_W        16
// self-clearing update location and bit
`define SPS_UPDATE_ADDR  16'h0232
`define SPS_UPDATE_MASK  8'h01
// byte framing
`define SPS_LAST_BIT     4'h7
`define SPS_BYTE_BITS    4'h8
// address byte phases
`define SPS_IDX_HI       2'h0
`define SPS_IDX_LO       2'h1
`define SPS_IDX_DATA     2'h2
// synchroniser: {strap_lo[1:0], strap_up[1:0], sleep_n, sda, scl}
`define SPS_SYNC_W       7
`define SPS_SYNC_RST     7'h07
`define SPS_B_SCL        0
`define SPS_B_SDA        1
`define SPS_B_SLEEP      2
`define SPS_B_UP         3
`define SPS_B_LO         5
// split point of the pointer into its two bus bytes
`define SPS_PTR_SPLIT    8

`endif

// *** design/sps_i2c_slave.v ***
`timescale 1ns/1ps
`include "sps_regs.vh"

// Function
// - four-wire port only when both straps high
// - bus address upper bits fixed 1011
// - strap pair maps to address low bits
// - works at 100 kHz and 400 kHz
// - slave only, never drives clock line
// - register address is sixteen bits, two bytes
// - data changes only while clock low
// - data fall, clock high, is start
// - data rise, clock high, is stop
// - eight bits, msb first, then ack slot
// - receiver acks by holding data low
// - released data on ninth pulse is nack
// - ack only own address, else stay idle
// - no limit on bytes per transfer
// - write: address high, low, then data
// - read: all bytes are register contents
// - read ends on nack; slave releases data
// - start or stop aborts, drops partial byte
// - address-only write sets current address
// - port keeps working during pin sleep
// - bare read starts at current address
// - writes buffered until update bit applies
module sps_i2c_slave (
	input  wire        mclk_in,
	input  wire        rst_b_in,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe_b_out,
	input  wire [1:0]  port_select_pin_upper_in,
	input  wire [1:0]  port_select_pin_lower_in,
	input  wire        chip_sleep_pin_n_in,
	output reg         spi_mode_out,
	output reg         core_sleep_out,
	input  wire [9:0]  act_rd_addr_in,
	output reg  [7:0]  act_rd_data_out
);

localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_ADDR = 7'h02;
localparam [6:0] ST_ACK  = 7'h04;
localparam [6:0] ST_RX   = 7'h08;
localparam [6:0] ST_TX   = 7'h10;
localparam [6:0] ST_MACK = 7'h20;
localparam [6:0] ST_IGN  = 7'h40;

localparam [`SPS_SYNC_W-1:0] SYNC_RST = `SPS_SYNC_RST;

////////////////////////////////////////////////////////////////////////////////
// helpers

function in_map;
	input [`SPS_PTR_W-1:0] a;
	begin
		in_map = (a[`SPS_PTR_W-1:`SPS_AW] == {(`SPS_PTR_W-`SPS_AW){1'b0}});
	end
endfunction

function [1:0] lvl_idx;
	input [1:0] lvl;
	begin
		case (lvl)
			`SPS_LVL_LOW:  lvl_idx = 2'h0;
			`SPS_LVL_HIGH: lvl_idx = 2'h2;
			default:       lvl_idx = 2'h1; // unknown code counts as open
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// input synchronisers: three flops, accept when second and third agree

wire [`SPS_SYNC_W-1:0] raw_in = {port_select_pin_lower_in, port_select_pin_upper_in,
	chip_sleep_pin_n_in, sda_in, scl_in};
reg  [`SPS_SYNC_W-1:0] s1_q;
reg  [`SPS_SYNC_W-1:0] s2_q;
reg  [`SPS_SYNC_W-1:0] s3_q;
reg  [`SPS_SYNC_W-1:0] flt_q;

always @(posedge mclk_in or negedge rst_b_in) begin
	if (!rst_b_in) begin
		s1_q <= SYNC_RST;
		s2_q <= SYNC_RST;
		s3_q <= SYNC_RST;
	end else begin
		s1_q <= raw_in;
		s2_q <= s1_q;
		s3_q <= s2_q;
	end
end

genvar g;
generate
	for (g = 0; g < `SPS_SYNC_W; g = g + 1) begin : g_flt
		always @(posedge mclk_in or negedge rst_b_in) begin
			if (!rst_b_in)
				flt_q[g] <= SYNC_RST[g];
			else if (s2_q[g] == s3_q[g])
				flt_q[g] <= s3_q[g];
		end
	end
endgenerate

// scl is only ever sampled; the block has no clock-line driver at all
wire scl_f = flt_q[`SPS_B_SCL];
wire sda_f = flt_q[`SPS_B_SDA];
reg  scl_p_q;
reg  sda_p_q;

always @(posedge mclk_in or negedge rst_b_in) begin
	if (!rst_b_in) begin
		scl_p_q <= 1'b1;
		sda_p_q <= 1'b1;
	end else begin
		scl_p_q <= scl_f;
		sda_p_q <= sda_f;
	end
end

// 10 ns sampling against a 2.5 us bit cell leaves ample margin
wire scl_rise = scl_f & ~scl_p_q;
wire scl_fall = ~scl_f & scl_p_q;
wire bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
wire bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;

////////////////////////////////////////////////////////////////////////////////
// straps and sleep pin

wire [1:0] up_idx = lvl_idx(flt_q[`SPS_B_UP+1:`SPS_B_UP]);
wire [1:0] lo_idx = lvl_idx(flt_q[`SPS_B_LO+1:`SPS_B_LO]);
wire [3:0] lo_sum = {1'b0, up_idx, 1'b0} + {2'b00, up_idx} + {2'b00, lo_idx};
wire       spi_sel = (up_idx == `SPS_LVL_HIGH) && (lo_idx == `SPS_LVL_HIGH);
wire [6:0] own_addr = {`SPS_ADDR_HI, lo_sum[2:0]};

always @(posedge mclk_in or negedge rst_b_in) begin
	if (!rst_b_in) begin
		spi_mode_out   <= 1'b0;
		core_sleep_out <= 1'b0;
	end else begin
		spi_mode_out   <= spi_sel;
		// sleep only reaches the core; the port below never looks at it
		core_sleep_out <= ~flt_q[`SPS_B_SLEEP];
	end
end

////////////////////////////////////////////////////////////////////////////////
// protocol engine

reg [6:0]            state_q;
reg [3:0]            cnt_q;
reg [7:0]            sr_q;
reg                  rw_q;
reg [1:0]            idx_q;
reg [`SPS_PTR_W-1:0] ptr_q;
reg                  oe_b_q;
reg                  mack_q;
reg                  upd_q;

reg [7:0] buf_mem [0:`SPS_DEPTH-1];
reg [7:0] act_mem [0:`SPS_DEPTH-1];

wire       byte_done = scl_fall && (cnt_q == `SPS_BYTE_BITS);
wire       is_upd    = (ptr_q == `SPS_UPDATE_ADDR);
wire       wr_en     = (state_q == ST_RX) && byte_done && (idx_q == `SPS_IDX_DATA)
	&& in_map(ptr_q);
wire [7:0] wr_data   = is_upd ? (sr_q & ~`SPS_UPDATE_MASK) : sr_q;
wire [7:0] rd_byte   = in_map(ptr_q) ? buf_mem[ptr_q[`SPS_AW-1:0]] : 8'h00;
wire       addr_hit  = (sr_q[7:1] == own_addr) && !spi_sel;

assign sda_out      = 1'b0;
assign sda_oe_b_out = oe_b_q;

always @(posedge mclk_in or negedge rst_b_in) begin
	if (!rst_b_in) begin
		state_q <= ST_IDLE;
		cnt_q   <= 4'h0;
		sr_q    <= 8'h00;
		rw_q    <= 1'b0;
		idx_q   <= `SPS_IDX_HI;
		ptr_q   <= {`SPS_PTR_W{1'b0}};
		oe_b_q  <= 1'b1;
		mack_q  <= 1'b0;
		upd_q   <= 1'b0;
	end else begin
		upd_q <= wr_en && is_upd && ((sr_q & `SPS_UPDATE_MASK) != 8'h00);
		if (bus_start) begin
			// repeated start is as good as a fresh one; partial byte dropped
			state_q <= ST_ADDR;
			cnt_q   <= 4'h0;
			idx_q   <= `SPS_IDX_HI;
			oe_b_q  <= 1'b1;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			cnt_q   <= 4'h0;
			oe_b_q  <= 1'b1;
		end else begin
			case (state_q)
				ST_ADDR, ST_RX: begin
					if (scl_rise && cnt_q != `SPS_BYTE_BITS) begin
						sr_q  <= {sr_q[6:0], sda_f};
						cnt_q <= cnt_q + 4'h1;
					end else if (byte_done) begin
						if (state_q == ST_ADDR) begin
							if (addr_hit) begin
								rw_q    <= sr_q[0];
								oe_b_q  <= 1'b0;
								state_q <= ST_ACK;
							end else begin
								state_q <= ST_IGN;
							end
						end else begin
							case (idx_q)
								`SPS_IDX_HI: ptr_q[`SPS_PTR_W-1:`SPS_PTR_SPLIT] <= sr_q;
								`SPS_IDX_LO: ptr_q[`SPS_PTR_SPLIT-1:0] <= sr_q;
								default:     ptr_q <= ptr_q + 16'h0001;
							endcase
							if (idx_q != `SPS_IDX_DATA)
								idx_q <= idx_q + 2'h1;
							oe_b_q  <= 1'b0;
							state_q <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							// first read byte from the held pointer
							sr_q    <= rd_byte;
							oe_b_q  <= rd_byte[7];
							ptr_q   <= ptr_q + 16'h0001;
							cnt_q   <= 4'h0;
							state_q <= ST_TX;
						end else begin
							oe_b_q  <= 1'b1;
							cnt_q   <= 4'h0;
							state_q <= ST_RX;
						end
					end
				end
				ST_TX: begin
					// data moves only on clock falls, so it is steady while high
					if (scl_fall) begin
						if (cnt_q == `SPS_LAST_BIT) begin
							oe_b_q  <= 1'b1;
							state_q <= ST_MACK;
						end else begin
							sr_q   <= {sr_q[6:0], 1'b0};
							oe_b_q <= sr_q[6];
							cnt_q  <= cnt_q + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise)
						mack_q <= ~sda_f;
					else if (scl_fall) begin
						if (mack_q) begin
							sr_q    <= rd_byte;
							oe_b_q  <= rd_byte[7];
							ptr_q   <= ptr_q + 16'h0001;
							cnt_q   <= 4'h0;
							state_q <= ST_TX;
						end else begin
							// nack ends the read; stay off the line until the next start or stop
							state_q <= ST_IGN;
						end
					end
				end
				ST_IGN:  oe_b_q <= 1'b1;
				ST_IDLE: oe_b_q <= 1'b1;
				default: begin
					state_q <= ST_IDLE;
					oe_b_q  <= 1'b1;
				end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// buffered and active register images

// the update bit is stored cleared, so it reads back as zero
always @(posedge mclk_in) begin
	if (wr_en)
		buf_mem[ptr_q[`SPS_AW-1:0]] <= wr_data;
end

// whole-image copy costs area but keeps every change simultaneous
integer i;
always @(posedge mclk_in) begin
	if (upd_q) begin
		for (i = 0; i < `SPS_DEPTH; i = i + 1)
			act_mem[i] <= buf_mem[i];
	end
end

always @(posedge mclk_in or negedge rst_b_in) begin
	if (!rst_b_in)
		act_rd_data_out <= 8'h00;
	else
		act_rd_data_out <= act_mem[act_rd_addr_in];
end

endmodule

// *** verif/sps_i2c_slave_props.sv ***
`timescale 1ns/1ps
module sps_i2c_slave_props(
	input wire       mclk_in,
	input wire       rst_b_in,
	input wire       scl_in,
	input wire       sda_in,
	input wire       sda_out,
	input wire       sda_oe_b_out,
	input wire [1:0] port_select_pin_upper_in,
	input wire [1:0] port_select_pin_lower_in,
	input wire       chip_sleep_pin_n_in,
	input wire       spi_mode_out,
	input wire       core_sleep_out,
	input wire [9:0] act_rd_addr_in,
	input wire [7:0] act_rd_data_out);
	wire both_hi = port_select_pin_upper_in == 2'h2 && port_select_pin_lower_in == 2'h2;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// eight samples cover the strap synchroniser latency
	property p_spi; both_hi [*8] |-> spi_mode_out; endproperty
	a_spi: assert property (p_spi) else $error("four-wire mode missing");
	property p_two; !both_hi [*8] |-> !spi_mode_out; endproperty
	a_two: assert property (p_two) else $error("two-wire mode missing");
	// open drain only, and never pulled while the four-wire port owns the pins
	property p_low; sda_out == 1'b0 && (sda_oe_b_out || !spi_mode_out); endproperty
	a_low: assert property (p_low) else $error("data pulled in four-wire mode");
	property p_slp; !chip_sleep_pin_n_in [*8] |-> core_sleep_out; endproperty
	a_slp: assert property (p_slp) else $error("sleep not seen");
	property p_wak; chip_sleep_pin_n_in [*8] |-> !core_sleep_out; endproperty
	a_wak: assert property (p_wak) else $error("wake not seen");
	property p_hold; scl_in [*2] |-> $stable(sda_oe_b_out); endproperty
	a_hold: assert property (p_hold) else $error("data moved in clock high");
	property p_grab; $fell(sda_oe_b_out) |-> !scl_in; endproperty
	a_grab: assert property (p_grab) else $error("drive began in clock high");
	property p_free; $rose(sda_oe_b_out) |-> !scl_in; endproperty
	a_free: assert property (p_free) else $error("release in clock high");
endmodule
bind sps_i2c_slave sps_i2c_slave_props u_props(
	.mclk_in                  (mclk_in),
	.rst_b_in                 (rst_b_in),
	.scl_in                   (scl_in),
	.sda_in                   (sda_in),
	.sda_out                  (sda_out),
	.sda_oe_b_out             (sda_oe_b_out),
	.port_select_pin_upper_in (port_select_pin_upper_in),
	.port_select_pin_lower_in (port_select_pin_lower_in),
	.chip_sleep_pin_n_in      (chip_sleep_pin_n_in),
	.spi_mode_out             (spi_mode_out),
	.core_sleep_out           (core_sleep_out),
	.act_rd_addr_in           (act_rd_addr_in),
	.act_rd_data_out          (act_rd_data_out));

// *** verif/sps_master.sv ***
`timescale 1ns/1ps
module sps_master(
	output reg  scl_out,
	output reg  sda_out,
	input  wire sda_in);
	// 125 ns link clock: half low, half high
	localparam real H = 62.5;
	// data moves off the sampling grid, early in the low phase
	localparam real T_DAT = 22.0;
	// sample late in the high phase, long after the far side settled
	localparam real T_SMP = 50.0;
	// released lines float high through the pull-up
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task bitx(input v, output r);
		#T_DAT sda_out = v;
		#(H - T_DAT) scl_out = 1'b1;
		#T_SMP r = sda_in;
		#(H - T_SMP) scl_out = 1'b0;
	endtask
	task start;
		#T_DAT sda_out = 1'b1;
		#(H - T_DAT) scl_out = 1'b1;
		#(H / 2) sda_out = 1'b0;
		#(H / 2) scl_out = 1'b0;
	endtask
	task stop;
		#T_DAT sda_out = 1'b0;
		#(H - T_DAT) scl_out = 1'b1;
		#(H / 2) sda_out = 1'b1;
		#H;
	endtask
	task xbyte(input [7:0] b, input last, output [7:0] r, output ack);
		integer i;
		for (i = 7; i >= 0; i--) bitx(b[i], r[i]);
		bitx(last, ack);
	endtask
endmodule

// *** verif/sps_i2c_slave_bench.sv ***
`timescale 1ns/1ps
module sps_i2c_slave_bench;
	reg        mclk_in = 1'b0, rst_b_in = 1'b0, sleep_n = 1'b1;
	reg  [1:0] up = 2'h0, lo = 2'h0;
	reg  [9:0] act_a = 10'h010;
	wire       scl, sda_m, sda_d, sda_oe_b, spi, csl;
	wire [7:0] act_d;
	wire       sda = sda_m & (sda_oe_b | sda_d);
	integer    err_count = 0, check_count = 0, cyc = 0, i, ptr;
	reg  [7:0] mem [int];
	reg  [7:0] r, d, old;
	reg  [6:0] sa;
	reg        k;
	always #5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			results;
		end
	end
	sps_i2c_slave u_sps_i2c_slave(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_d), .sda_oe_b_out(sda_oe_b),
		.port_select_pin_upper_in(up), .port_select_pin_lower_in(lo),
		.chip_sleep_pin_n_in(sleep_n), .spi_mode_out(spi), .core_sleep_out(csl),
		.act_rd_addr_in(act_a), .act_rd_data_out(act_d));
	sps_master u_sps_master(.scl_out(scl), .sda_out(sda_m), .sda_in(sda));
	////////////////////////////////////////////////////////////////
	task chk(input [7:0] g, input [7:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task chk_bit(input g, input e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t flag %b want %b", $time, g, e);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wb(input [7:0] b);
		u_sps_master.xbyte(b, 1'b1, r, k);
		chk_bit(k, 1'b0);
	endtask
	task wr(input [15:0] a, input integer n);
		integer j;
		u_sps_master.start;
		wb({sa, 1'b0});
		wb(a[15:8]);
		wb(a[7:0]);
		ptr = a;
		for (j = 0; j < n; j++) begin
			d = (a == 16'h0232) ? 8'h01 : 8'($urandom);
			wb(d);
			mem[ptr] = (ptr == 16'h0232) ? 8'h00 : d;
			ptr++;
		end
		u_sps_master.stop;
	endtask
	task rd(input integer n);
		integer j;
		u_sps_master.start;
		wb({sa, 1'b1});
		for (j = 0; j < n; j++) begin
			u_sps_master.xbyte(8'hff, j == n - 1, r, k);
			chk(r, mem[ptr]);
			ptr++;
		end
		u_sps_master.stop;
	endtask
	initial begin
		i = $urandom(32'h2a93);
		repeat (3) @(negedge mclk_in);
		rst_b_in = 1'b1;
		for (i = 0; i < 9; i++) begin
			@(negedge mclk_in);
			up = 2'(i / 3);
			lo = 2'(i % 3);
			repeat (20) @(negedge mclk_in);
			chk_bit(spi, i == 8);
			sa = 7'h58 + 7'(i);
			u_sps_master.start;
			u_sps_master.xbyte({sa ^ 7'h04, 1'b0}, 1'b1, r, k);
			chk_bit(k, 1'b1);
			u_sps_master.start;
			u_sps_master.xbyte({sa, 1'b0}, 1'b1, r, k);
			chk_bit(k, i == 8);
			u_sps_master.stop;
		end
		i = $urandom % 8;
		@(negedge mclk_in);
		up = 2'(i / 3);
		lo = 2'(i % 3);
		sa = 7'h58 + 7'(i);
		sleep_n = 1'b0;
		repeat (20) @(negedge mclk_in);
		chk_bit(csl, 1'b1);
		wr(16'h0010, 4);
		wr(16'h0010, 0);
		rd(3);
		rd(1);
		old = mem[16];
		wr(16'h0232, 1);
		repeat (4) @(negedge mclk_in);
		chk(act_d, old);
		wr(16'h0010, 1);
		wr(16'h0232, 0);
		rd(1);
		chk(act_d, old);
		u_sps_master.start;
		wb({sa, 1'b0});
		wb(8'h00);
		wb(8'h10);
		// a few stray bits must not land anywhere
		repeat (7) u_sps_master.bitx(1'b0, k);
		ptr = 16;
		rd(1);
		@(negedge mclk_in);
		sleep_n = 1'b1;
		repeat (20) @(negedge mclk_in);
		chk_bit(csl, 1'b0);
		results;
	end
endmodule
